// [design/pin_sync.sv]
`timescale 1ns/1ps
`default_nettype none

module pin_sync #(
   parameter int W = 8
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic [W-1:0] din,
   output var logic [W-1:0] dout
);

   logic [W-1:0] s1_r;
   logic [W-1:0] s2_r;
   logic [W-1:0] s3_r;
   logic agree;

   // first stage is looked at by the second stage only
   assign agree = (s2_r == s3_r);

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         s1_r <= '0;
         s2_r <= '0;
         s3_r <= '0;
         dout <= '0;
      end else begin
         s1_r <= din;
         s2_r <= s1_r;
         s3_r <= s2_r;
         if (agree) begin
            dout <= s3_r;
         end
      end
   end

endmodule

`default_nettype wire

// [design/vram_host.sv]
`timescale 1ns/1ps
`default_nettype none

module vram_host (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output var logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   output var vram_host_pkg::pins_t pins,
   input wire logic [7:0] mask_data_in
);

   typedef enum logic [2:0] {
      S_IDLE,
      S_ROW_SET,
      S_ROW_HOLD,
      S_COL_SET,
      S_CAS_LOW,
      S_CAS_HIGH,
      S_PAGE,
      S_RAS_WAIT
   } state_t;

   state_t st_r, st_nxt;
   logic [7:0] cnt_r, cnt_nxt;
   logic [7:0] ras_cnt_r;
   logic [7:0] prech_r;
   logic [2:0] op_r;
   logic mask_en_r;
   logic keep_r;
   logic [8:0] row_r;
   logic [8:0] col_r;
   logic [7:0] data_r;
   logic [7:0] pmask_r;
   logic [31:0] cmd_reg_r;
   logic [17:0] addr_reg_r;
   logic [15:0] wdata_reg_r;
   logic [7:0] rdata_r;
   logic refused_r;
   logic done_r;
   logic colour_ok_r;
   vram_host_pkg::pins_t pins_nxt;
   logic [7:0] din_sync;

   pin_sync #(
      .W(8)
   ) u_din_sync (
      .pclk(pclk),
      .presetn(presetn),
      .din(mask_data_in),
      .dout(din_sync)
   );

   // bus decode
   wire access = psel && penable;
   wire wr_en = access && pwrite;
   wire setup = psel && !penable;
   wire hit_cmd = (paddr == vram_host_pkg::REG_CMD);
   wire hit_addr = (paddr == vram_host_pkg::REG_ADDR);
   wire hit_wdata = (paddr == vram_host_pkg::REG_WDATA);
   wire hit_status = (paddr == vram_host_pkg::REG_STATUS);
   wire hit_rdata = (paddr == vram_host_pkg::REG_RDATA);
   wire mapped = hit_cmd || hit_addr || hit_wdata || hit_status || hit_rdata;
   // zero wait states: every register answers in its own access cycle
   assign pready = 1'b1;
   assign pslverr = access && !mapped;

   // command acceptance
   wire [2:0] cmd_op = pwdata[vram_host_pkg::CMD_OP_LSB +: 3];
   wire cmd_wr = wr_en && hit_cmd;
   wire is_block_op = (cmd_op == vram_host_pkg::OP_BLOCK_WR) ||
                      (cmd_op == vram_host_pkg::OP_MASKED_BLOCK_WR);
   wire op_legal = (cmd_op <= vram_host_pkg::OP_MASKED_BLOCK_WR);
   wire colour_gate = !is_block_op || colour_ok_r;
   wire idle_ok = (st_r == S_IDLE) && (cmd_op != vram_host_pkg::OP_CLOSE);
   wire state_ok = idle_ok || (st_r == S_PAGE);
   wire cmd_take = cmd_wr && op_legal && colour_gate && state_ok;
   wire cmd_refuse = cmd_wr && !cmd_take;

   // cycle kinds of the running command
   wire op_read = (op_r == vram_host_pkg::OP_READ);
   wire op_late = (op_r == vram_host_pkg::OP_LATE_WR);
   wire op_lcr = (op_r == vram_host_pkg::OP_COLOUR_LOAD);
   wire op_bw = (op_r == vram_host_pkg::OP_BLOCK_WR);
   wire op_mbw = (op_r == vram_host_pkg::OP_MASKED_BLOCK_WR);
   wire op_early = !op_read && !op_late;
   // plane mask only for masked writes; colour load must keep it high at row fall
   wire mask_at_row = op_mbw || (mask_en_r && !op_lcr && !op_bw && !op_read);
   wire dsf_at_col = op_lcr || op_bw;
   wire [7:0] cas_len = op_read ? vram_host_pkg::T_CAS_RD_CYC :
                        (op_late ? vram_host_pkg::T_CAS_LW_CYC : vram_host_pkg::T_CAS_CYC);
   wire ras_min_met = (ras_cnt_r >= vram_host_pkg::T_RAS_CYC);
   // a read holds the column strobe long enough to cover the input synchroniser
   wire cas_end = (cnt_r >= cas_len - 8'd1);
   wire ras_rise = !pins.row_strobe_n && pins_nxt.row_strobe_n;
   wire cycle_done = (st_r == S_CAS_HIGH) && (st_nxt != S_CAS_HIGH);
   // block write column addresses keep their low bits; the device ignores them
   wire [8:0] col_sel = col_r;

   always_comb begin
      st_nxt = st_r;
      cnt_nxt = cnt_r + 8'd1;
      unique case (st_r)
         S_IDLE: begin
            cnt_nxt = 8'd0;
            if (cmd_take) begin
               st_nxt = S_ROW_SET;
            end
         end
         S_ROW_SET: begin
            // first cycle may still show the last row; the new one needs a cycle of setup
            cnt_nxt = 8'd1;
            if ((prech_r == 8'd0) && (cnt_r != 8'd0)) begin
               st_nxt = S_ROW_HOLD;
               cnt_nxt = 8'd0;
            end
         end
         S_ROW_HOLD: begin
            if (cnt_r >= vram_host_pkg::T_RCD_CYC - 8'd1) begin
               st_nxt = S_COL_SET;
               cnt_nxt = 8'd0;
            end
         end
         S_COL_SET: begin
            // two cycles: a page command's new column and data land one cycle late
            cnt_nxt = 8'd1;
            if (cnt_r != 8'd0) begin
               st_nxt = S_CAS_LOW;
               cnt_nxt = 8'd0;
            end
         end
         S_CAS_LOW: begin
            if (cas_end) begin
               st_nxt = S_CAS_HIGH;
               cnt_nxt = 8'd0;
            end
         end
         S_CAS_HIGH: begin
            if (cnt_r >= vram_host_pkg::T_CP_CYC - 8'd1) begin
               st_nxt = keep_r ? S_PAGE : S_RAS_WAIT;
               cnt_nxt = 8'd0;
            end
         end
         S_PAGE: begin
            cnt_nxt = 8'd0;
            if (cmd_take) begin
               st_nxt = (cmd_op == vram_host_pkg::OP_CLOSE) ? S_RAS_WAIT : S_COL_SET;
            end
         end
         S_RAS_WAIT: begin
            cnt_nxt = 8'd0;
            if (ras_min_met) begin
               st_nxt = S_IDLE;
            end
         end
      endcase
   end

   // pin levels follow the state being entered, so each pin changes from a flop
   always_comb begin
      pins_nxt = pins;
      pins_nxt.row_strobe_n = 1'b0;
      pins_nxt.column_strobe_n = 1'b1;
      pins_nxt.write_enable_mask_select_n = 1'b1;
      pins_nxt.transfer_output_enable_n = 1'b1;
      pins_nxt.mask_data_oe = 1'b0;
      unique case (st_nxt)
         S_IDLE: begin
            pins_nxt.row_strobe_n = 1'b1;
            pins_nxt.special_function_select = 1'b0;
         end
         S_ROW_SET, S_ROW_HOLD: begin
            pins_nxt.row_strobe_n = (st_nxt == S_ROW_SET);
            pins_nxt.addr = row_r;
            pins_nxt.special_function_select = op_lcr;
            pins_nxt.write_enable_mask_select_n = !mask_at_row;
            pins_nxt.mask_data_out = pmask_r;
            pins_nxt.mask_data_oe = mask_at_row;
         end
         S_COL_SET, S_CAS_LOW: begin
            pins_nxt.column_strobe_n = (st_nxt == S_COL_SET);
            pins_nxt.addr = col_sel;
            pins_nxt.special_function_select = dsf_at_col;
            pins_nxt.mask_data_out = data_r;
            pins_nxt.mask_data_oe = !op_read;
            pins_nxt.transfer_output_enable_n = !op_read;
            if (op_late) begin
               pins_nxt.write_enable_mask_select_n =
                  !((st_nxt == S_CAS_LOW) && (cnt_nxt >= vram_host_pkg::T_WLATE_CYC));
            end else begin
               pins_nxt.write_enable_mask_select_n = !op_early;
            end
         end
         S_CAS_HIGH, S_PAGE, S_RAS_WAIT: begin
            pins_nxt.special_function_select = 1'b0;
         end
      endcase
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         st_r <= S_IDLE;
         cnt_r <= 8'd0;
         pins <= vram_host_pkg::PINS_IDLE;
      end else begin
         st_r <= st_nxt;
         cnt_r <= cnt_nxt;
         pins <= pins_nxt;
      end
   end

   // row low width and precharge timers
   // saturate rather than wrap, so a long open page still reads as width met
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ras_cnt_r <= 8'd0;
         prech_r <= 8'd0;
      end else begin
         if (pins.row_strobe_n) begin
            ras_cnt_r <= 8'd0;
         end else if (ras_cnt_r != 8'hFF) begin
            ras_cnt_r <= ras_cnt_r + 8'd1;
         end
         if (ras_rise) begin
            prech_r <= vram_host_pkg::T_RP_CYC;
         end else if (prech_r != 8'd0) begin
            prech_r <= prech_r - 8'd1;
         end
      end
   end

   // command snapshot; a page command keeps the open row and its mask
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         op_r <= vram_host_pkg::OP_CLOSE;
         mask_en_r <= 1'b0;
         keep_r <= 1'b0;
         row_r <= vram_host_pkg::ADDR_RESET;
         col_r <= vram_host_pkg::ADDR_RESET;
         data_r <= vram_host_pkg::DATA_RESET;
         pmask_r <= vram_host_pkg::DATA_RESET;
      end else if (cmd_take && (cmd_op != vram_host_pkg::OP_CLOSE)) begin
         op_r <= cmd_op;
         keep_r <= pwdata[vram_host_pkg::CMD_KEEP_BIT];
         col_r <= addr_reg_r[vram_host_pkg::AD_COL_LSB +: 9];
         data_r <= wdata_reg_r[vram_host_pkg::WD_DATA_LSB +: 8];
         if (st_r == S_IDLE) begin
            mask_en_r <= pwdata[vram_host_pkg::CMD_MASK_BIT];
            row_r <= addr_reg_r[vram_host_pkg::AD_ROW_LSB +: 9];
            pmask_r <= wdata_reg_r[vram_host_pkg::WD_PMASK_LSB +: 8];
         end
      end
   end

   // software registers
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cmd_reg_r <= 32'h0000_0000;
         addr_reg_r <= 18'h0_0000;
         wdata_reg_r <= 16'h0000;
      end else if (wr_en) begin
         if (hit_cmd) begin
            cmd_reg_r <= {27'h000_0000, pwdata[4:0]};
         end
         if (hit_addr) begin
            addr_reg_r <= pwdata[17:0];
         end
         if (hit_wdata) begin
            wdata_reg_r <= pwdata[15:0];
         end
      end
   end

   // sticky flags: a new event wins over a same-cycle write-one clear
   wire clr_wr = wr_en && hit_status;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         refused_r <= 1'b0;
         done_r <= 1'b0;
         colour_ok_r <= 1'b0;
         rdata_r <= vram_host_pkg::DATA_RESET;
      end else begin
         refused_r <= cmd_refuse || (refused_r && !(clr_wr && pwdata[vram_host_pkg::ST_REFUSED]));
         done_r <= cycle_done || (done_r && !(clr_wr && pwdata[vram_host_pkg::ST_DONE]));
         if (cycle_done && op_lcr) begin
            colour_ok_r <= 1'b1;
         end
         if ((st_r == S_CAS_LOW) && cas_end && op_read) begin
            rdata_r <= din_sync;
         end
      end
   end

   wire busy = (st_r != S_IDLE) && (st_r != S_PAGE);
   wire [31:0] status_word = {27'h000_0000, colour_ok_r, done_r, refused_r,
                              !pins.row_strobe_n, busy};
   wire [31:0] rd_mux = hit_cmd ? cmd_reg_r :
                        hit_addr ? {14'h0000, addr_reg_r} :
                        hit_wdata ? {16'h0000, wdata_reg_r} :
                        hit_status ? status_word :
                        hit_rdata ? {24'h00_0000, rdata_r} : 32'h0000_0000;

   // read data captured in the setup cycle, stable through the access phase
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata <= 32'h0000_0000;
      end else if (setup) begin
         prdata <= rd_mux;
      end
   end

endmodule

`default_nettype wire

// [design/vram_host_pkg.sv]
package vram_host_pkg;

   // clock and timing
   localparam int CLK_MHZ = 200;
   localparam int T_RP_NS = 50;
   localparam int T_RAS_NS = 60;
   localparam int T_RCD_NS = 20;
   localparam int T_CAS_NS = 15;
   localparam int T_CAC_NS = 20;
   localparam int T_CP_NS = 10;
   localparam int T_WLATE_NS = 5;
   localparam int T_WP_NS = 10;
   localparam int SYNC_LAT = 3;

   // least times round up to whole cycles
   localparam logic [7:0] T_RP_CYC = 8'((T_RP_NS * CLK_MHZ + 999) / 1000);
   localparam logic [7:0] T_RAS_CYC = 8'((T_RAS_NS * CLK_MHZ + 999) / 1000);
   localparam logic [7:0] T_RCD_CYC = 8'((T_RCD_NS * CLK_MHZ + 999) / 1000);
   localparam logic [7:0] T_CAS_CYC = 8'((T_CAS_NS * CLK_MHZ + 999) / 1000);
   localparam logic [7:0] T_CAS_RD_CYC = 8'((T_CAC_NS * CLK_MHZ + 999) / 1000 + SYNC_LAT);
   localparam logic [7:0] T_CP_CYC = 8'((T_CP_NS * CLK_MHZ + 999) / 1000);
   localparam logic [7:0] T_WLATE_CYC = 8'((T_WLATE_NS * CLK_MHZ + 999) / 1000);
   localparam logic [7:0] T_CAS_LW_CYC = 8'(((T_WLATE_NS + T_WP_NS) * CLK_MHZ + 999) / 1000);

   // register offsets (byte addresses)
   localparam logic [7:0] REG_CMD = 8'h00;
   localparam logic [7:0] REG_ADDR = 8'h04;
   localparam logic [7:0] REG_WDATA = 8'h08;
   localparam logic [7:0] REG_STATUS = 8'h0C;
   localparam logic [7:0] REG_RDATA = 8'h10;

   // command register fields
   localparam int CMD_OP_LSB = 0;
   localparam int CMD_MASK_BIT = 3;
   localparam int CMD_KEEP_BIT = 4;
   // wdata register fields
   localparam int WD_DATA_LSB = 0;
   localparam int WD_PMASK_LSB = 8;
   // address register fields
   localparam int AD_ROW_LSB = 0;
   localparam int AD_COL_LSB = 9;
   // status bits
   localparam int ST_BUSY = 0;
   localparam int ST_ROW_OPEN = 1;
   localparam int ST_REFUSED = 2;
   localparam int ST_DONE = 3;
   localparam int ST_COLOUR_OK = 4;

   // command codes
   localparam logic [2:0] OP_CLOSE = 3'h0;
   localparam logic [2:0] OP_READ = 3'h1;
   localparam logic [2:0] OP_EARLY_WR = 3'h2;
   localparam logic [2:0] OP_LATE_WR = 3'h3;
   localparam logic [2:0] OP_COLOUR_LOAD = 3'h4;
   localparam logic [2:0] OP_BLOCK_WR = 3'h5;
   localparam logic [2:0] OP_MASKED_BLOCK_WR = 3'h6;

   localparam logic [8:0] ADDR_RESET = 9'h000;
   localparam logic [7:0] DATA_RESET = 8'h00;

   typedef struct packed {
      logic row_strobe_n;
      logic column_strobe_n;
      logic write_enable_mask_select_n;
      logic transfer_output_enable_n;
      logic special_function_select;
      logic [8:0] addr;
      logic [7:0] mask_data_out;
      logic mask_data_oe;
   } pins_t;

   localparam pins_t PINS_IDLE = '{
      row_strobe_n: 1'b1,
      column_strobe_n: 1'b1,
      write_enable_mask_select_n: 1'b1,
      transfer_output_enable_n: 1'b1,
      special_function_select: 1'b0,
      addr: ADDR_RESET,
      mask_data_out: DATA_RESET,
      mask_data_oe: 1'b0
   };

endpackage

// [dv/tb_vram_host.sv]
`timescale 1ns/1ps
`default_nettype none
module tb_vram_host;
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr, se;
   logic [7:0] paddr, d, m, c;
   logic [31:0] pwdata, prdata, rd, seed, r;
   logic [17:0] a;
   wire logic [7:0] dq;
   vram_host_pkg::pins_t pins;
   int err_total, checks_done, cyc;
   logic [7:0] exp_mem [logic [17:0]];
   vram_host u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .pins(pins), .mask_data_in(dq));
   vram_dev_model u_dev (.pins(pins), .dq(dq));
   initial begin
      pclk = 1'b0;
      forever #2.5 pclk = ~pclk;
   end
   always @(posedge pclk) begin
      cyc++;
      if (cyc == 20000) begin
         err_total++;
         stop_test();
      end
   end
   function automatic logic [31:0] rnd();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction
   function automatic logic [7:0] ex(input logic [17:0] k);
      return exp_mem.exists(k) ? exp_mem[k] : 8'h00;
   endfunction
   task automatic check(input logic [31:0] seen, input logic [31:0] want);
      checks_done++;
      if (seen !== want) begin
         err_total++;
         $display("unexpected at %0t: got %h want %h", $time, seen, want);
      end
   endtask
   task automatic apb(input logic w, input logic [7:0] ad, input logic [31:0] wd);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= ad;
      pwdata <= wd;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      rd = prdata;
      se = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask
   task automatic op(input logic [2:0] o, input logic [15:0] wd, input logic [1:0] f);
      int n;
      apb(1'b1, vram_host_pkg::REG_WDATA, 32'(wd));
      apb(1'b1, vram_host_pkg::REG_ADDR, 32'(a));
      apb(1'b1, vram_host_pkg::REG_CMD, {27'h000_0000, f, o});
      n = 0;
      do begin
         apb(1'b0, vram_host_pkg::REG_STATUS, 32'h0000_0000);
         n++;
      end while (rd[3] !== 1'b1 && n < 100);
      check(32'(rd[3:2]), 32'h0000_0002);
      apb(1'b1, vram_host_pkg::REG_STATUS, 32'h0000_000c);
   endtask
   task automatic rdback(input logic [1:0] f);
      op(vram_host_pkg::OP_READ, 16'h0000, f);
      apb(1'b0, vram_host_pkg::REG_RDATA, 32'h0000_0000);
      check(rd, 32'(ex(a)));
   endtask
   task automatic refuse(input logic [2:0] o);
      apb(1'b1, vram_host_pkg::REG_CMD, 32'(o));
      apb(1'b0, vram_host_pkg::REG_STATUS, 32'h0000_0000);
      check(32'(rd[2]), 32'h0000_0001);
      apb(1'b1, vram_host_pkg::REG_STATUS, 32'h0000_000c);
   endtask
   task automatic stop_test();
      $display("comparisons %0d mismatches %0d", checks_done, err_total);
      if (err_total == 0 && checks_done > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask
   initial begin
      seed = 32'h9aa4_a7b0;
      presetn = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h00;
      pwdata = 32'h0000_0000;
      repeat (12) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      check(32'(pins), 32'(vram_host_pkg::PINS_IDLE));
      apb(1'b0, vram_host_pkg::REG_STATUS, 32'h0000_0000);
      check(rd, 32'h0000_0000);
      apb(1'b0, 8'h14, 32'h0000_0000);
      check({rd[30:0], se}, 32'h0000_0001);
      refuse(vram_host_pkg::OP_CLOSE);
      refuse(vram_host_pkg::OP_BLOCK_WR);
      $display("reset and refusal test done");
      repeat (16) begin
         a = 18'(rnd());
         d = 8'(rnd());
         m = 8'(rnd());
         r = rnd();
         // mask enable only in r[1]; a plain write must see all planes again
         op(r[0] ? vram_host_pkg::OP_LATE_WR : vram_host_pkg::OP_EARLY_WR, {m, d}, {1'b0, r[1]});
         if (!r[1])
            m = 8'hff;
         exp_mem[a] = (ex(a) & ~m) | (d & m);
         rdback(2'b00);
      end
      $display("random write test done");
      c = 8'(rnd());
      a = {9'h01f, 9'h155};
      op(vram_host_pkg::OP_COLOUR_LOAD, {8'h00, c}, 2'b00);
      apb(1'b0, vram_host_pkg::REG_STATUS, 32'h0000_0000);
      check(32'(rd[4]), 32'h0000_0001);
      op(vram_host_pkg::OP_BLOCK_WR, 16'h0005, 2'b00);
      for (int i = 0; i < 4; i++) begin
         a[10:9] = 2'(i);
         if (i % 2 == 0)
            exp_mem[a] = c;
         rdback(2'b00);
      end
      $display("block write test done");
      a = {9'h000, 9'(rnd())};
      op(vram_host_pkg::OP_EARLY_WR, 16'h003c, 2'b10);
      exp_mem[a] = 8'h3c;
      apb(1'b0, vram_host_pkg::REG_STATUS, 32'h0000_0000);
      check(32'(rd[1]), 32'h0000_0001);
      a[17:9] = 9'h1ff;
      op(vram_host_pkg::OP_EARLY_WR, 16'h00c3, 2'b10);
      exp_mem[a] = 8'hc3;
      rdback(2'b10);
      a[17:9] = 9'h000;
      rdback(2'b10);
      apb(1'b1, vram_host_pkg::REG_CMD, 32'(vram_host_pkg::OP_CLOSE));
      repeat (40) apb(1'b0, vram_host_pkg::REG_STATUS, 32'h0000_0000);
      check(32'(rd[1:0]), 32'h0000_0000);
      apb(1'b1, vram_host_pkg::REG_STATUS, 32'h0000_000c);
      $display("page mode test done");
      a = {9'h040, 9'h1a0};
      op(vram_host_pkg::OP_MASKED_BLOCK_WR, 16'h0f05, 2'b01);
      $display("masked block write test done");
      stop_test();
   end
endmodule
`default_nettype wire

// [dv/vram_dev_model.sv]
`timescale 1ns/1ps
`default_nettype none
module vram_dev_model (
   input wire vram_host_pkg::pins_t pins,
   output wire logic [7:0] dq
);
   logic [7:0] mem [logic [17:0]];
   logic [7:0] colour, pmask, q, last;
   logic [8:0] row, col;
   logic sfs_row, rd;
   wire logic drv = rd && !pins.transfer_output_enable_n && !pins.column_strobe_n;
   // released bus shows the inverse of its last value, not a stale copy
   assign dq = pins.mask_data_oe ? pins.mask_data_out : (drv ? q : ~last);
   initial begin
      last = 8'h00;
      rd = 1'b0;
   end
   always @(pins.mask_data_out or q or pins.mask_data_oe or drv) begin
      if (pins.mask_data_oe)
         last = pins.mask_data_out;
      else if (drv)
         last = q;
   end
   function automatic logic [7:0] get(input logic [17:0] k);
      return mem.exists(k) ? mem[k] : 8'h00;
   endfunction
   task automatic put(input logic [17:0] k, input logic [7:0] v);
      mem[k] = (get(k) & ~pmask) | (v & pmask);
   endtask
   always @(negedge pins.row_strobe_n) begin
      if (pins.column_strobe_n) begin
         row = pins.addr;
         sfs_row = pins.special_function_select;
         pmask = pins.write_enable_mask_select_n ? 8'hff : dq;
      end
   end
   always @(negedge pins.column_strobe_n) begin
      if (!pins.row_strobe_n) begin
         col = pins.addr;
         rd = 1'b0;
         if (pins.special_function_select && sfs_row) begin
            if (!pins.write_enable_mask_select_n)
               colour = dq;
         end else if (pins.special_function_select) begin
            for (int i = 0; i < 4; i++)
               if (dq[i])
                  put({row, col[8:2], 2'(i)}, colour);
         end else if (!pins.write_enable_mask_select_n) begin
            put({row, col}, dq);
         end else begin
            rd = 1'b1;
            q = get({row, col});
         end
      end
   end
   always @(negedge pins.write_enable_mask_select_n) begin
      if (rd && !pins.column_strobe_n) begin
         rd = 1'b0;
         put({row, col}, dq);
      end
   end
endmodule
`default_nettype wire

// [dv/vram_host_checker.sv]
`timescale 1ns/1ps
`default_nettype none
module vram_host_checker (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   input wire vram_host_pkg::pins_t pins,
   input wire logic [7:0] mask_data_in
);
   logic [7:0] ras_hi_r, ras_lo_r, cas_lo_r;
   wire logic ras_n = pins.row_strobe_n;
   wire logic cas_n = pins.column_strobe_n;
   wire logic we_n = pins.write_enable_mask_select_n;
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   // saturating run lengths of row strobe high, row strobe low and column strobe low
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ras_hi_r <= 8'h00;
         ras_lo_r <= 8'h00;
         cas_lo_r <= 8'h00;
      end else begin
         ras_hi_r <= (ras_n && ras_hi_r != 8'hff) ? ras_hi_r + 8'h01 : (ras_n ? ras_hi_r : 8'h00);
         ras_lo_r <= (!ras_n && ras_lo_r != 8'hff) ? ras_lo_r + 8'h01 : (ras_n ? 8'h00 : ras_lo_r);
         cas_lo_r <= (!cas_n && cas_lo_r != 8'hff) ? cas_lo_r + 8'h01 : (cas_n ? 8'h00 : cas_lo_r);
      end
   end
   property p_row_first;
      $fell(ras_n) |-> cas_n && $stable(pins.addr);
   endproperty
   a_row_first: assert property (p_row_first)
      else $error("row strobe fell without column strobe high");
   property p_precharge;
      $fell(ras_n) |-> ras_hi_r >= vram_host_pkg::T_RP_CYC;
   endproperty
   a_precharge: assert property (p_precharge)
      else $error("row precharge too short");
   property p_ras_width;
      $rose(ras_n) |-> ras_lo_r >= vram_host_pkg::T_RAS_CYC;
   endproperty
   a_ras_width: assert property (p_ras_width)
      else $error("row strobe low too short");
   property p_cas_width;
      $rose(cas_n) |-> cas_lo_r >= vram_host_pkg::T_CAS_CYC;
   endproperty
   a_cas_width: assert property (p_cas_width)
      else $error("column strobe low too short");
   property p_col_addr;
      $fell(cas_n) |-> !ras_n && $stable(pins.addr);
   endproperty
   a_col_addr: assert property (p_col_addr)
      else $error("column address not set up under open row");
   property p_read_pins;
      !pins.transfer_output_enable_n |-> we_n && !pins.mask_data_oe;
   endproperty
   a_read_pins: assert property (p_read_pins)
      else $error("output enable low while writing or driving");
   property p_cycle_end;
      $rose(ras_n) |-> cas_n && pins.transfer_output_enable_n;
   endproperty
   a_cycle_end: assert property (p_cycle_end)
      else $error("row closed with column strobe low");
   property p_wr_data;
      $fell(cas_n) && !we_n |-> pins.mask_data_oe && $stable(pins.mask_data_out);
   endproperty
   a_wr_data: assert property (p_wr_data)
      else $error("write data not driven at column strobe");
   property p_mask_ras;
      $fell(ras_n) && !we_n |-> pins.mask_data_oe;
   endproperty
   a_mask_ras: assert property (p_mask_ras)
      else $error("plane mask not driven at row strobe");
   c_read: cover property ($rose(pins.transfer_output_enable_n));
   c_late: cover property ($fell(we_n) && !cas_n);
   c_block: cover property ($fell(cas_n) && pins.special_function_select && !we_n);
endmodule
bind vram_host vram_host_checker u_chk (.pclk(pclk), .presetn(presetn), .psel(psel),
   .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
   .pready(pready), .pslverr(pslverr), .pins(pins), .mask_data_in(mask_data_in));
`default_nettype wire
